//--- logic/debug_pkg.sv
package debug_pkg;

  // system clock and serial link timing
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned LINK_BAUD      = 115_200;
  localparam int unsigned BIT_CYCLES     = CLK_HZ / LINK_BAUD;
  localparam int unsigned CORE_RESET_NS  = 200;
  localparam int unsigned CORE_RESET_CYC =
    (CORE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_COUNTER = 5'h04;
  localparam logic [4:0] OFF_STATUS  = 5'h08;
  localparam logic [4:0] OFF_MASK    = 5'h0c;

  // debug_control field positions
  localparam int unsigned BIT_DEBUG_STATE = 7;
  localparam int unsigned BIT_BRK_ENABLE  = 6;
  localparam int unsigned BIT_ACK_ENABLE  = 5;
  localparam int unsigned BIT_LOOP_SELECT = 4;
  localparam int unsigned BIT_PC_BREAK    = 3;
  localparam int unsigned BIT_ZERO_BREAK  = 2;
  localparam int unsigned BIT_RESERVED    = 1;
  localparam int unsigned BIT_RESET       = 0;

  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [15:0] COUNTER_RESET   = 16'h0000;
  localparam logic [7:0]  BRK_OPCODE      = 8'h00;
  localparam logic [7:0]  ACK_CHARACTER   = 8'hff;

  // interrupt status and mask layout
  localparam int unsigned EVT_COUNT     = 3;
  localparam int unsigned EVT_BRK_ENTRY = 0;
  localparam int unsigned EVT_PC_MATCH  = 1;
  localparam int unsigned EVT_ACK_SENT  = 2;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b11,
    TX_STOP  = 2'b10
  } tx_state_e;

endpackage

//--- logic/ack_serial_tx.sv
`timescale 1ns/10ps
module ack_serial_tx
  import debug_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // character request
  input  wire logic       start,
  input  wire logic [7:0] char_in,
  output wire logic       busy,
  output logic            done,
  // open-drain pin, driven only while low
  output wire logic       pin_out,
  output logic            pin_oe
);

  generate
    if (BIT_CYC < 2 || BIT_CYC > 65536) begin : g_chk
      $error("ack_serial_tx: BIT_CYC must be 2 to 65536");
    end
  endgenerate

  tx_state_e   state_reg;
  tx_state_e   state_next;
  logic [15:0] tick_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  shift_reg;

  wire logic tick_end = (tick_reg == 16'(BIT_CYC - 1));

  assign busy    = (state_reg != TX_IDLE);
  assign pin_out = 1'b0;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TX_IDLE:  if (start) state_next = TX_START;
      TX_START: if (tick_end) state_next = TX_DATA;
      TX_DATA:  if (tick_end && bit_reg == 3'd7) state_next = TX_STOP;
      TX_STOP:  if (tick_end) state_next = TX_IDLE;
      default:  state_next = TX_IDLE;
    endcase
  end

  // rs-232 style frame: one start bit low, eight data bits lsb first, one stop bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= TX_IDLE;
      tick_reg  <= 16'h0000;
      bit_reg   <= 3'd0;
      shift_reg <= 8'h00;
      pin_oe    <= 1'b0;
      done      <= 1'b0;
    end else begin
      state_reg <= state_next;
      done      <= (state_reg == TX_STOP) && tick_end;
      tick_reg  <= (state_reg == TX_IDLE || tick_end) ? 16'h0000 : tick_reg + 16'h0001;
      if (state_reg == TX_IDLE && start) begin
        shift_reg <= char_in;
        bit_reg   <= 3'd0;
      end else if (state_reg == TX_DATA && tick_end) begin
        shift_reg <= {1'b0, shift_reg[7:1]};
        bit_reg   <= bit_reg + 3'd1;
      end
      case (state_next)
        TX_START: pin_oe <= 1'b1;
        TX_DATA:  pin_oe <= (state_reg == TX_START) ? ~shift_reg[0]
                          : (tick_end ? ~shift_reg[1] : pin_oe);
        default:  pin_oe <= 1'b0;
      endcase
    end
  end

endmodule

//--- logic/debug_control_breakpoint.sv
`timescale 1ns/10ps
module debug_control_breakpoint
  import debug_pkg::*;
#(
  parameter int unsigned RESET_CYC = CORE_RESET_CYC,
  parameter int unsigned BIT_CYC   = BIT_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output wire logic        waitrequest,
  // control writes decoded from the host link
  input  wire logic        host_ctrl_wr,
  input  wire logic [7:0]  host_ctrl_data,
  // core observation and control
  input  wire logic        opcode_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic        pc_valid,
  input  wire logic [15:0] pc,
  input  wire logic        read_protect,
  output logic             core_reset,
  output wire logic        fetch_halt,
  output logic             repeat_break,
  // debug serial pin, open drain, plus receiver activity
  input  wire logic        link_rx_busy,
  output wire logic        dbg_pin_out,
  output wire logic        dbg_pin_oe,
  // interrupt
  output wire logic        irq
);

  generate
    if (RESET_CYC < 1 || RESET_CYC > 65535) begin : g_chk
      $error("debug_control_breakpoint: RESET_CYC out of range");
    end
  endgenerate

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a[4:2] == off[4:2];
  endfunction

  logic [7:0]           control_reg;
  logic [15:0]          counter_reg;
  logic [EVT_COUNT-1:0] status_reg;
  logic [EVT_COUNT-1:0] mask_reg;
  logic                 ack_reg;
  logic [15:0]          rst_cnt_reg;
  logic                 ack_pend_reg;
  logic [7:0]           control_next;

  // bus decode: every request waits exactly one cycle
  wire logic req       = read | write;
  wire logic wr_go     = write & ack_reg;
  wire logic sel_ctrl  = hit(address, OFF_CONTROL);
  wire logic sel_cnt   = hit(address, OFF_COUNTER);
  wire logic sel_stat  = hit(address, OFF_STATUS);
  wire logic sel_mask  = hit(address, OFF_MASK);
  wire logic sw_ctrl   = wr_go & sel_ctrl & byteenable[0];
  wire logic ctrl_wr   = sw_ctrl | host_ctrl_wr;
  wire logic [7:0] wdata = host_ctrl_wr ? host_ctrl_data : writedata[7:0];

  assign waitrequest = req & ~ack_reg;

  wire logic [31:0] rd_mux =
      sel_ctrl ? {24'h00_0000, control_reg[7:2], 1'b0, control_reg[0]}
    : sel_cnt  ? {16'h0000, counter_reg}
    : sel_stat ? {{(32-EVT_COUNT){1'b0}}, status_reg}
    : sel_mask ? {{(32-EVT_COUNT){1'b0}}, mask_reg}
    : 32'h0000_0000;

  // breakpoint detection, blocked while the core is held in reset or stopped
  wire logic in_reset  = (rst_cnt_reg != 16'h0000);
  wire logic dbg_bit   = control_reg[BIT_DEBUG_STATE];
  wire logic brk_seen  = opcode_valid & (opcode == BRK_OPCODE) & ~in_reset & ~dbg_bit;
  wire logic brk_live  = brk_seen & control_reg[BIT_BRK_ENABLE];
  wire logic brk_enter = brk_live & ~control_reg[BIT_LOOP_SELECT];
  wire logic brk_loop  = brk_live & control_reg[BIT_LOOP_SELECT];
  wire logic pc_hit    = pc_valid & control_reg[BIT_PC_BREAK] & ~in_reset
                       & ~dbg_bit & (pc == counter_reg);
  wire logic brk_event = brk_live | pc_hit;

  assign fetch_halt = dbg_bit | in_reset;

  // a zero to the debug bit is dropped under read protect unless it resets
  wire logic protect_hold = read_protect & dbg_bit & ~wdata[BIT_RESET];

  always_comb begin
    control_next = control_reg;
    if (ctrl_wr) begin
      control_next = wdata;
      control_next[BIT_RESERVED] = 1'b0;
      if (protect_hold)
        control_next[BIT_DEBUG_STATE] = 1'b1;
    end
    // a fresh reset write in the last count cycle keeps its reset bit
    if (in_reset && rst_cnt_reg == 16'h0001 && !(ctrl_wr && wdata[BIT_RESET]))
      control_next[BIT_RESET] = 1'b0;
    // hardware entry wins over a clear in the same cycle
    if (brk_enter || pc_hit)
      control_next[BIT_DEBUG_STATE] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_reg <= CONTROL_RESET;
      counter_reg <= COUNTER_RESET;
      mask_reg    <= '0;
      ack_reg     <= 1'b0;
      readdata    <= 32'h0000_0000;
    end else begin
      control_reg <= control_next;
      ack_reg     <= req & ~ack_reg;
      if (req && !ack_reg)
        readdata <= rd_mux;
      if (wr_go && sel_cnt && byteenable[0])
        counter_reg[7:0] <= writedata[7:0];
      if (wr_go && sel_cnt && byteenable[1])
        counter_reg[15:8] <= writedata[15:8];
      if (wr_go && sel_mask && byteenable[0])
        mask_reg <= writedata[EVT_COUNT-1:0];
    end
  end

  // core reset pulse; the debug bit written with it decides stop or go
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_cnt_reg  <= 16'h0000;
      core_reset   <= 1'b0;
      repeat_break <= 1'b0;
    end else begin
      if (ctrl_wr && wdata[BIT_RESET])
        rst_cnt_reg <= 16'(RESET_CYC);
      else if (in_reset)
        rst_cnt_reg <= rst_cnt_reg - 16'h0001;
      core_reset   <= (ctrl_wr && wdata[BIT_RESET]) || rst_cnt_reg > 16'h0001;
      repeat_break <= brk_loop;
    end
  end

  // acknowledge character: waits while the host is talking
  logic tx_busy;
  logic tx_done;
  wire logic tx_start = ack_pend_reg & ~tx_busy & ~link_rx_busy;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      ack_pend_reg <= 1'b0;
    else if (brk_event && control_reg[BIT_ACK_ENABLE])
      ack_pend_reg <= 1'b1;
    else if (tx_start)
      ack_pend_reg <= 1'b0;
  end

  ack_serial_tx #(
    .BIT_CYC (BIT_CYC)
  ) u_tx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tx_start),
    .char_in (ACK_CHARACTER),
    .busy    (tx_busy),
    .done    (tx_done),
    .pin_out (dbg_pin_out),
    .pin_oe  (dbg_pin_oe)
  );

  // sticky events, write one to clear, a new event beats the clear
  wire logic [EVT_COUNT-1:0] evt;
  assign evt[EVT_BRK_ENTRY] = brk_enter;
  assign evt[EVT_PC_MATCH]  = pc_hit;
  assign evt[EVT_ACK_SENT]  = tx_done;

  genvar gi;
  generate
    for (gi = 0; gi < EVT_COUNT; gi++) begin : g_evt
      wire logic clr = wr_go & sel_stat & byteenable[0] & writedata[gi];
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
          status_reg[gi] <= 1'b0;
        else if (evt[gi])
          status_reg[gi] <= 1'b1;
        else if (clr)
          status_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(status_reg & mask_reg);

  // length of the last core reset pulse, read by the reset length check
  logic [15:0] rst_len_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      rst_len_reg <= 16'h0000;
    else if (!core_reset)
      rst_len_reg <= 16'h0000;
    else
      rst_len_reg <= rst_len_reg + 16'h0001;
  end

  // checks
  wire logic wr81 = ctrl_wr & (wdata == 8'h81);
  wire logic wr41 = ctrl_wr & (wdata == 8'h41);
  wire logic wr40 = ctrl_wr & (wdata == 8'h40) & dbg_bit & ~read_protect;

  property p_reset_stop;
    @(posedge clk_sys) disable iff (rst)
    wr81 |=> core_reset ##0 dbg_bit;
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("81H did not reset and stop");

  property p_reset_go;
    @(posedge clk_sys) disable iff (rst)
    wr41 && !brk_event |=> core_reset && !dbg_bit;
  endproperty
  a_reset_go: assert property (p_reset_go) else $error("41H did not reset and run");

  property p_run;
    @(posedge clk_sys) disable iff (rst)
    wr40 && !brk_enter && !pc_hit && (rst_cnt_reg <= 16'h0001) |=> !fetch_halt;
  endproperty
  a_run: assert property (p_run) else $error("40H did not resume the core");

  property p_halt;
    @(posedge clk_sys) disable iff (rst)
    dbg_bit |-> fetch_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("fetch not stopped in debug state");

  property p_brk_enter;
    @(posedge clk_sys) disable iff (rst)
    brk_enter |=> dbg_bit && status_reg[EVT_BRK_ENTRY];
  endproperty
  a_brk_enter: assert property (p_brk_enter) else $error("break did not enter debug");

  property p_brk_loop;
    @(posedge clk_sys) disable iff (rst)
    brk_loop && !pc_hit && !ctrl_wr |=> repeat_break && !dbg_bit;
  endproperty
  a_brk_loop: assert property (p_brk_loop) else $error("loop break mishandled");

  property p_brk_nop;
    @(posedge clk_sys) disable iff (rst)
    brk_seen && !control_reg[BIT_BRK_ENABLE] && !pc_hit && !ctrl_wr |=> !dbg_bit && !repeat_break;
  endproperty
  a_brk_nop: assert property (p_brk_nop) else $error("disabled break had an effect");

  property p_protect;
    @(posedge clk_sys) disable iff (rst)
    read_protect && dbg_bit && ctrl_wr && !wdata[BIT_RESET] |=> dbg_bit;
  endproperty
  a_protect: assert property (p_protect) else $error("protected debug bit cleared");

  property p_ack;
    @(posedge clk_sys) disable iff (rst)
    brk_event && control_reg[BIT_ACK_ENABLE] && !tx_busy && !ack_pend_reg && !link_rx_busy
      ##1 !link_rx_busy |=> dbg_pin_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("ack character not started");

  property p_pc;
    @(posedge clk_sys) disable iff (rst)
    pc_hit |=> dbg_bit ##0 status_reg[EVT_PC_MATCH];
  endproperty
  a_pc: assert property (p_pc) else $error("pc match did not break");

  property p_half;
    @(posedge clk_sys) disable iff (rst)
    link_rx_busy && !tx_busy |=> !tx_busy;
  endproperty
  a_half: assert property (p_half) else $error("sent while host was talking");

  property p_rst_len;
    @(posedge clk_sys) disable iff (rst)
    $fell(core_reset) |-> rst_len_reg >= 16'(RESET_CYC);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("core reset pulse too short");

  property p_halt_reset;
    @(posedge clk_sys) disable iff (rst)
    core_reset |-> fetch_halt;
  endproperty
  a_halt_reset: assert property (p_halt_reset) else $error("fetch ran during core reset");

  property p_bit0_clear;
    @(posedge clk_sys) disable iff (rst)
    $fell(core_reset) |-> !control_reg[BIT_RESET];
  endproperty
  a_bit0_clear: assert property (p_bit0_clear) else $error("reset bit not cleared");

  property p_pin_idle;
    @(posedge clk_sys) disable iff (rst)
    !tx_busy |-> !dbg_pin_oe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin driven while idle");

  property p_pend_hold;
    @(posedge clk_sys) disable iff (rst)
    ack_pend_reg && link_rx_busy |=> ack_pend_reg;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending ack lost");

  property p_ack_done;
    @(posedge clk_sys) disable iff (rst)
    tx_done |=> status_reg[EVT_ACK_SENT];
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("ack sent not flagged");

  property p_counter_wr;
    @(posedge clk_sys) disable iff (rst)
    wr_go && sel_cnt && byteenable[1:0] == 2'b11 |=> counter_reg == $past(writedata[15:0]);
  endproperty
  a_counter_wr: assert property (p_counter_wr) else $error("counter write lost");

  property p_status_clr;
    @(posedge clk_sys) disable iff (rst)
    wr_go && sel_stat && byteenable[0] && writedata[EVT_PC_MATCH] && !pc_hit
      |=> !status_reg[EVT_PC_MATCH];
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status bit not cleared");

  property p_bus_wait;
    @(posedge clk_sys) disable iff (rst)
    waitrequest |=> !waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("more than one wait cycle");

  c_stop: cover property (@(posedge clk_sys) disable iff (rst) wr81);
  c_brk:  cover property (@(posedge clk_sys) disable iff (rst) brk_enter);
  c_loop: cover property (@(posedge clk_sys) disable iff (rst) brk_loop ##1 brk_loop);
  c_ack:  cover property (@(posedge clk_sys) disable iff (rst) tx_done);

endmodule

//--- tb/host_debugger_model.sv
`timescale 1ns/10ps
module host_debugger_model #(
  parameter int unsigned BIT_CYC = 4
) (
  // clock and line
  input  wire logic       clk_sys,
  input  wire logic       pin,
  input  wire logic       dev_oe,
  // host side state
  output logic            host_oe,
  output logic            rx_busy,
  output logic [7:0]      last_char,
  output logic [7:0]      n_char,
  output logic [7:0]      n_err,
  output logic [7:0]      n_coll
);
  logic [9:0] tx_frame;
  logic [9:0] rx_frame;
  initial begin
    host_oe = 1'b0;
    rx_busy = 1'b0;
    last_char = 8'h00;
    n_char = 8'h00;
    n_err = 8'h00;
    n_coll = 8'h00;
  end
  // start bit, 8 data bits lsb first, stop bit; released line floats high on the pull-up
  task automatic send_char(input logic [7:0] c);
    @(posedge clk_sys);
    tx_frame = {1'b1, c, 1'b0};
    rx_busy <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      host_oe <= ~tx_frame[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
    rx_busy <= 1'b0;
  endtask
  // own frames are not received: the link is half duplex
  always begin
    @(posedge clk_sys);
    if (!rx_busy && pin === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
        rx_frame[i] = pin;
        repeat (BIT_CYC) @(posedge clk_sys);
      end
      if (rx_frame[0] !== 1'b0 || rx_frame[9] !== 1'b1) begin
        n_err <= n_err + 8'h01;
      end
      last_char <= rx_frame[8:1];
      n_char <= n_char + 8'h01;
    end
  end
  always @(posedge clk_sys) begin
    if (rx_busy && dev_oe) begin
      n_coll <= n_coll + 8'h01;
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import debug_pkg::*;
  localparam int unsigned RST_C = 4;
  localparam int unsigned BIT_C = 4;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic        host_ctrl_wr = 1'b0;
  logic [7:0]  host_ctrl_data = 8'h00;
  logic        opcode_valid = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic        pc_valid = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic        read_protect = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest, core_reset, fetch_halt, repeat_break;
  logic        dbg_pin_out, dbg_pin_oe, irq, host_oe, link_rx_busy;
  logic [7:0]  last_char, n_char, n_err, n_coll;
  wire logic   pin;
  int          n_mismatch = 0;
  int          compares = 0;
  assign pin = ~((dbg_pin_oe & ~dbg_pin_out) | host_oe);
  always #25 clk_sys = ~clk_sys;
  debug_control_breakpoint #(.RESET_CYC(RST_C), .BIT_CYC(BIT_C)) debug_control_breakpoint_i (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .host_ctrl_wr(host_ctrl_wr), .host_ctrl_data(host_ctrl_data), .opcode_valid(opcode_valid),
    .opcode(opcode), .pc_valid(pc_valid), .pc(pc), .read_protect(read_protect),
    .core_reset(core_reset), .fetch_halt(fetch_halt), .repeat_break(repeat_break),
    .link_rx_busy(link_rx_busy), .dbg_pin_out(dbg_pin_out), .dbg_pin_oe(dbg_pin_oe), .irq(irq));
  host_debugger_model #(.BIT_CYC(BIT_C)) host_debugger_model_i (
    .clk_sys(clk_sys), .pin(pin), .dev_oe(dbg_pin_oe), .host_oe(host_oe),
    .rx_busy(link_rx_busy), .last_char(last_char), .n_char(n_char), .n_err(n_err),
    .n_coll(n_coll));
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) chk(1'b0, 1'b1, "bus never answered");
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e, m);
  endtask
  // kind 0 opcode, 1 program counter, 2 host control write
  task automatic pulse(input int k, input logic [15:0] v);
    @(posedge clk_sys);
    opcode_valid <= (k == 0);
    opcode <= v[7:0];
    pc_valid <= (k == 1);
    pc <= v;
    host_ctrl_wr <= (k == 2);
    host_ctrl_data <= v[7:0];
    @(posedge clk_sys);
    opcode_valid <= 1'b0;
    pc_valid <= 1'b0;
    host_ctrl_wr <= 1'b0;
  endtask
  task automatic halt_chk(input logic e, input string m);
    repeat (2) @(negedge clk_sys);
    chk(fetch_halt, e, m);
  endtask
  task automatic rst_count(input string m);
    int n;
    n = 0;
    while (core_reset !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (core_reset === 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n, RST_C, m);
  endtask
  task automatic wait_char(input logic [7:0] k);
    int n;
    n = 0;
    while (n_char !== k && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n_char, k, "ack character count");
    chk(last_char, ACK_CHARACTER, "ack character value");
    chk({n_err, n_coll}, 16'h0000, "frame or collision on pin");
  endtask
  task automatic t_defaults;
    rd_chk(OFF_CONTROL, 32'h0000_0000, "control reset value");
    rd_chk(OFF_COUNTER, 32'h0000_0000, "counter reset value");
    rd_chk(OFF_STATUS, 32'h0000_0000, "status reset value");
    rd_chk(OFF_MASK, 32'h0000_0000, "mask reset value");
    rd_chk(5'h10, 32'h0000_0000, "unmapped read");
    chk({irq, core_reset, fetch_halt}, 3'b000, "outputs after reset");
  endtask
  task automatic t_reset_stop;
    wr(OFF_CONTROL, 32'h0000_0081);
    rst_count("reset length on 81");
    halt_chk(1'b1, "stopped after reset and stop");
    rd_chk(OFF_CONTROL, 32'h0000_0080, "debug bit set, reset bit cleared");
    pulse(2, 16'h0040);
    halt_chk(1'b0, "run from host link");
    rd_chk(OFF_CONTROL, 32'h0000_0040, "control after run");
  endtask
  task automatic t_nop;
    wr(OFF_CONTROL, 32'h0000_0000);
    pulse(0, BRK_OPCODE);
    halt_chk(1'b0, "disabled break opcode halted");
    chk(repeat_break, 1'b0, "disabled break opcode looped");
  endtask
  task automatic t_break;
    wr(OFF_CONTROL, 32'h0000_0060);
    pulse(0, BRK_OPCODE);
    halt_chk(1'b1, "break did not halt");
    rd_chk(OFF_CONTROL, 32'h0000_00e0, "debug bit not set by break");
    wait_char(8'h01);
    rd_chk(OFF_STATUS, 32'h0000_0005, "status after break and ack");
    chk(irq, 1'b0, "masked irq");
    wr(OFF_MASK, 32'h0000_0007);
    @(negedge clk_sys);
    chk(irq, 1'b1, "unmasked irq");
    wr(OFF_STATUS, 32'h0000_0007);
    @(negedge clk_sys);
    chk(irq, 1'b0, "irq after clear");
    rd_chk(OFF_STATUS, 32'h0000_0000, "status after clear");
    wr(OFF_CONTROL, 32'h0000_0040);
    halt_chk(1'b0, "clearing debug bit did not resume");
  endtask
  task automatic t_loop_duplex;
    wr(OFF_CONTROL, 32'h0000_0070);
    fork
      host_debugger_model_i.send_char(8'h5a);
      begin
        repeat (3) @(posedge clk_sys);
        pulse(0, BRK_OPCODE);
        @(negedge clk_sys);
        chk(repeat_break, 1'b1, "loop break pulse");
        @(negedge clk_sys);
        chk({repeat_break, fetch_halt}, 2'b00, "loop break lasts one cycle");
        chk(dbg_pin_oe, 1'b0, "sent while host was sending");
      end
    join
    wait_char(8'h02);
  endtask
  task automatic t_pc_protect;
    wr(OFF_STATUS, 32'h0000_0007);
    wr(OFF_COUNTER, 32'h0000_1234);
    rd_chk(OFF_COUNTER, 32'h0000_1234, "counter readback");
    wr(OFF_CONTROL, 32'h0000_0008);
    pulse(1, 16'h1233);
    halt_chk(1'b0, "pc mismatch halted");
    pulse(1, 16'h1234);
    halt_chk(1'b1, "pc match did not halt");
    rd_chk(OFF_STATUS, 32'h0000_0002, "pc match status");
    read_protect <= 1'b1;
    wr(OFF_CONTROL, 32'h0000_0008);
    halt_chk(1'b1, "protected debug bit cleared by bus");
    pulse(2, 16'h0040);
    halt_chk(1'b1, "protected debug bit cleared by host");
    wr(OFF_CONTROL, 32'h0000_0041);
    rst_count("reset length on 41");
    halt_chk(1'b0, "reset and go stayed halted");
    rd_chk(OFF_CONTROL, 32'h0000_0040, "control after reset and go");
    read_protect <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_defaults;
    t_reset_stop;
    t_nop;
    t_break;
    t_loop_duplex;
    t_pc_protect;
    end_sim;
  end
endmodule
